// ### logic/fma_pkg.sv
// Constants and types for the fixed-point arithmetic section.
// Assumes a 36-bit ones-complement word and one 200 MHz clock.
package fma_pkg;
    // =========================================================
    // Word geometry
    localparam int W      = 36;
    localparam int DW     = 72;
    localparam int HW     = 18;
    localparam int TW     = 12;
    localparam int MAGW   = 35;
    localparam int DMAGW  = 71;
    // =========================================================
    // Field codes
    localparam logic [3:0]  J_HI_A     = 4'hE;
    localparam logic [3:0]  J_HI_B     = 4'hF;
    localparam logic [3:0]  A_CTRL     = 4'hF;
    localparam logic [15:0] U_ALL_ONES = 16'hFFFF;
    localparam logic [3:0]  X_NONE     = 4'h0;
    localparam logic [3:0]  X_CLASH_0  = 4'hD;
    localparam logic [3:0]  X_CLASH_1  = 4'hE;
    localparam logic [3:0]  X_CLASH_2  = 4'hF;
    localparam logic [3:0]  A_CLASH_0  = 4'h0;
    localparam logic [3:0]  A_CLASH_1  = 4'h1;
    localparam logic [3:0]  A_CLASH_2  = 4'h2;
    localparam logic [7:0]  CTRL_ADDR_LO = 8'h1C;
    localparam logic [7:0]  CTRL_ADDR_HI = 8'h7C;
    // =========================================================
    // Register port
    localparam logic [3:0]  REG_CTRL   = 4'h0;
    localparam logic [3:0]  REG_STATUS = 4'h4;
    localparam int          CTRL_BANK  = 0;
    localparam int          ST_FAULT   = 0;
    localparam int          ST_OVF     = 1;
    localparam int          ST_CARRY   = 2;
    localparam int          ST_UNDEF   = 3;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    // =========================================================
    // Operations
    typedef enum logic [3:0] {
        FMA_OP_NONE   = 4'h0,
        FMA_OP_FMUL   = 4'h1,
        FMA_OP_IDIV   = 4'h2,
        FMA_OP_SFDIV  = 4'h3,
        FMA_OP_FDIV   = 4'h4,
        FMA_OP_DADD   = 4'h5,
        FMA_OP_DSUB   = 4'h6,
        FMA_OP_HADD   = 4'h7,
        FMA_OP_HSUB   = 4'h8,
        FMA_OP_TADD   = 4'h9
    } fma_op_t;

    typedef struct packed {
        fma_op_t      op;
        logic [3:0]   a_field;
        logic [3:0]   j_field;
        logic [3:0]   x_field;
        logic         incr;
        logic         indir;
        logic [15:0]  u_field;
        logic [W-1:0] acc_sel;
        logic [W-1:0] acc_next;
        logic [W-1:0] oper;
        logic [W-1:0] oper_next;
    } fma_req_t;

    typedef struct packed {
        logic [W-1:0] sel_data;
        logic [W-1:0] next_data;
        logic         sel_wr;
        logic         next_wr;
        logic [7:0]   next_addr;
        logic         next_is_ctrl;
    } fma_res_t;
endpackage : fma_pkg

// ### logic/fma_alu.sv
// Fixed-point multiply, divide, double and part-word add section.
// Assumes instruction control presents one request per strobe and takes
// results from the registered result bundle one cycle later.
//
// Implementation choices: strobed register access and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none
module fma_alu
    import fma_pkg::*;
(
    input  wire logic        clock,
    input  wire logic        reset_n,
    input  wire logic        req_valid,
    input  wire fma_req_t    req,
    output logic             res_valid,
    output fma_res_t         res,
    output logic             divide_fault,
    output logic             overflow_flag,
    output logic             carry_flag,
    output logic             low_undefined,
    input  wire logic [3:0]  reg_addr,
    input  wire logic [31:0] reg_wdata,
    input  wire logic        reg_write,
    input  wire logic        reg_read,
    output logic [31:0]      reg_rdata
);
    // =========================================================
    // Ones-complement helpers
    function automatic logic [DW:0] oc_add(input logic [DW-1:0] x,
                                           input logic [DW-1:0] y,
                                           input int w);
        logic [DW:0]   mask;
        logic [DW+1:0] s;
        logic          c;
        mask = (({{DW{1'b0}}, 1'b1} << w) - 1'b1);
        s = {2'b00, x & mask[DW-1:0]} + {2'b00, y & mask[DW-1:0]};
        c = s[w];
        s = (s + {{DW+1{1'b0}}, c}) & {1'b0, mask};
        if (s[DW:0] == mask && !((x & mask[DW-1:0]) == mask[DW-1:0]
                                 && (y & mask[DW-1:0]) == mask[DW-1:0])) begin
            s = '0;
        end
        oc_add = {c, s[DW-1:0]};
    endfunction : oc_add

    function automatic logic [MAGW-1:0] mag36(input logic [W-1:0] v);
        mag36 = v[W-1] ? ~v[MAGW-1:0] : v[MAGW-1:0];
    endfunction : mag36

    function automatic logic [DMAGW-1:0] mag72(input logic [DW-1:0] v);
        mag72 = v[DW-1] ? ~v[DMAGW-1:0] : v[DMAGW-1:0];
    endfunction : mag72

    function automatic logic [W-1:0] sgn36(input logic neg, input logic [MAGW-1:0] m);
        sgn36 = neg ? ~{1'b0, m} : {1'b0, m};
    endfunction : sgn36

    // =========================================================
    // Control register
    logic        bank_ff;
    logic [31:0] rdata_ff;
    logic        fault_ff;
    logic        ovf_ff;
    logic        carry_ff;
    logic        undef_ff;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            bank_ff <= CTRL_RESET[CTRL_BANK];
        end else if (reg_write && reg_addr == REG_CTRL) begin
            bank_ff <= reg_wdata[CTRL_BANK];
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            rdata_ff <= '0;
        end else if (reg_read) begin
            if (reg_addr == REG_CTRL) begin
                rdata_ff <= {31'h0000_0000, bank_ff};
            end else if (reg_addr == REG_STATUS) begin
                rdata_ff <= {28'h000_0000, undef_ff, carry_ff, ovf_ff, fault_ff};
            end else begin
                rdata_ff <= '0;
            end
        end else begin
            rdata_ff <= '0;
        end
    end
    assign reg_rdata = rdata_ff;

    // =========================================================
    // Operand selection
    logic          zero_sub;
    logic [W-1:0]  u_val;
    logic          clash;

    assign zero_sub = (req.j_field == J_HI_A || req.j_field == J_HI_B)
                      && req.x_field == X_NONE && req.incr && req.indir
                      && req.u_field == U_ALL_ONES;
    assign u_val    = zero_sub ? '0 : req.oper;
    assign clash    = req.incr
                      && ((req.x_field == X_CLASH_0 && req.a_field == A_CLASH_0)
                       || (req.x_field == X_CLASH_1 && req.a_field == A_CLASH_1)
                       || (req.x_field == X_CLASH_2 && req.a_field == A_CLASH_2));

    // =========================================================
    // Multiply and divide datapath
    logic [DW-1:0]    pair;
    logic [DW-1:0]    pair_rot;
    logic [MAGW-1:0]  v_mag;
    logic [DMAGW-1:0] prod_mag;
    logic [DW-1:0]    prod;
    logic [DMAGW-1:0] rot_mag;
    logic [DMAGW-1:0] pair_mag;
    logic [DMAGW-1:0] div_num;
    logic [DMAGW-1:0] div_q;
    logic [DMAGW-1:0] div_r;
    logic             dvd_neg;
    logic             q_neg;
    logic             div_bad;
    logic             is_div;

    assign pair     = {req.acc_sel, req.acc_next};
    assign pair_rot = {pair[DW-2:0], pair[DW-1]};
    assign v_mag    = mag36(u_val);
    assign prod_mag = DMAGW'(mag36(req.acc_sel)) * DMAGW'(v_mag);
    assign rot_mag  = mag72(pair_rot);
    assign pair_mag = mag72(pair);
    assign prod     = (req.acc_sel[W-1] ^ u_val[W-1]) ? ~{1'b0, prod_mag}
                                                      : {1'b0, prod_mag};
    assign is_div   = req.op == FMA_OP_IDIV || req.op == FMA_OP_SFDIV
                      || req.op == FMA_OP_FDIV;

    always_comb begin
        dvd_neg = req.acc_sel[W-1];
        div_num = '0;
        div_bad = 1'b0;
        if (req.op == FMA_OP_IDIV) begin
            // Fraction divider halves; rotation restores integer scale
            div_num = {1'b0, rot_mag[DMAGW-1:1]};
            dvd_neg = pair_rot[DW-1];
            div_bad = v_mag == '0 || div_num >= ({{MAGW+1{1'b0}}, v_mag} << MAGW);
        end else if (req.op == FMA_OP_SFDIV) begin
            div_num = {1'b0, mag36(req.acc_sel), {MAGW{1'b0}}};
            div_bad = mag36(req.acc_sel) >= v_mag;
        end else if (req.op == FMA_OP_FDIV) begin
            div_num = {1'b0, pair_mag[DMAGW-1:1]};
            div_bad = mag36(req.acc_sel) >= v_mag;
        end
    end

    assign q_neg = dvd_neg ^ u_val[W-1];
    assign div_q = div_bad ? '0 : div_num / {{DMAGW-MAGW{1'b0}}, v_mag};
    assign div_r = div_bad ? '0 : div_num % {{DMAGW-MAGW{1'b0}}, v_mag};

    // =========================================================
    // Add datapath
    logic [DW:0]   dsum;
    logic [DW-1:0] dopnd;
    logic          dovf;
    logic [W-1:0]  part;
    logic [W-1:0]  pw_u;

    assign dopnd = (req.op == FMA_OP_DSUB) ? ~{req.oper, req.oper_next}
                                           : {req.oper, req.oper_next};
    assign dsum  = oc_add(pair, dopnd, DW);
    assign dovf  = (pair[DW-1] == dopnd[DW-1]) && (dsum[DW-1] != pair[DW-1]);
    assign pw_u  = (req.op == FMA_OP_HSUB) ? ~u_val : u_val;

    always_comb begin
        logic [DW:0] t0;
        logic [DW:0] t1;
        logic [DW:0] t2;
        t0 = '0;
        t1 = '0;
        t2 = '0;
        part = req.acc_sel;
        if (req.op == FMA_OP_HADD || req.op == FMA_OP_HSUB) begin
            t0 = oc_add({54'h0, req.acc_sel[HW-1:0]}, {54'h0, pw_u[HW-1:0]}, HW);
            t1 = oc_add({54'h0, req.acc_sel[W-1:HW]}, {54'h0, pw_u[W-1:HW]}, HW);
            part = {t1[HW-1:0], t0[HW-1:0]};
        end else if (req.op == FMA_OP_TADD) begin
            t0 = oc_add({60'h0, req.acc_sel[TW-1:0]}, {60'h0, u_val[TW-1:0]}, TW);
            t1 = oc_add({60'h0, req.acc_sel[2*TW-1:TW]}, {60'h0, u_val[2*TW-1:TW]}, TW);
            t2 = oc_add({60'h0, req.acc_sel[W-1:2*TW]}, {60'h0, u_val[W-1:2*TW]}, TW);
            part = {t2[TW-1:0], t1[TW-1:0], t0[TW-1:0]};
        end
    end

    // =========================================================
    // Result bundle
    fma_res_t nxt_res;

    always_comb begin
        nxt_res = '0;
        nxt_res.next_is_ctrl = req.a_field == A_CTRL;
        nxt_res.next_addr = (req.a_field == A_CTRL) ? (bank_ff ? CTRL_ADDR_HI
                                                              : CTRL_ADDR_LO)
                                                    : {4'h0, req.a_field + 4'h1};
        case (req.op)
            FMA_OP_FMUL: begin
                nxt_res.sel_data  = prod[DW-2:W-1];
                nxt_res.next_data = {prod[W-2:0], prod[DW-1]};
                nxt_res.sel_wr    = 1'b1;
                nxt_res.next_wr   = 1'b1;
            end
            FMA_OP_IDIV, FMA_OP_FDIV: begin
                nxt_res.sel_data  = sgn36(q_neg, div_q[MAGW-1:0]);
                nxt_res.next_data = sgn36(req.acc_sel[W-1], div_r[MAGW-1:0]);
                nxt_res.sel_wr    = !div_bad;
                nxt_res.next_wr   = !div_bad;
            end
            FMA_OP_SFDIV: begin
                nxt_res.next_data = sgn36(q_neg, div_q[MAGW-1:0]);
                nxt_res.next_wr   = !div_bad;
            end
            FMA_OP_DADD, FMA_OP_DSUB: begin
                nxt_res.sel_data  = dsum[DW-1:W];
                nxt_res.next_data = dsum[W-1:0];
                nxt_res.sel_wr    = 1'b1;
                nxt_res.next_wr   = 1'b1;
            end
            FMA_OP_HADD, FMA_OP_HSUB, FMA_OP_TADD: begin
                nxt_res.sel_data  = part;
                nxt_res.sel_wr    = 1'b1;
            end
            default: begin
                nxt_res.sel_data  = '0;
            end
        endcase
    end

    fma_res_t res_ff;
    logic     valid_ff;
    fma_op_t  op_ff;

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            res_ff   <= '0;
            valid_ff <= 1'b0;
            op_ff    <= FMA_OP_NONE;
        end else begin
            valid_ff <= req_valid;
            if (req_valid) begin
                res_ff <= nxt_res;
                op_ff  <= req.op;
            end
        end
    end

    // =========================================================
    // Fault and designators
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            fault_ff <= 1'b0;
            undef_ff <= 1'b0;
        end else if (req_valid) begin
            fault_ff <= is_div && div_bad;
            undef_ff <= (req.op == FMA_OP_IDIV || req.op == FMA_OP_FDIV) && clash;
        end else begin
            fault_ff <= 1'b0;
            undef_ff <= 1'b0;
        end
    end

    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            ovf_ff   <= 1'b0;
            carry_ff <= 1'b0;
        end else if (req_valid && (req.op == FMA_OP_DADD || req.op == FMA_OP_DSUB)) begin
            ovf_ff   <= dovf;
            carry_ff <= dsum[DW];
        end
    end

    assign res_valid     = valid_ff;
    assign res           = res_ff;
    assign divide_fault  = fault_ff;
    assign overflow_flag = ovf_ff;
    assign carry_flag    = carry_ff;
    assign low_undefined = undef_ff;

    // =========================================================
    // Checks
    a_mul_sign_bit: assert property (@(posedge clock) disable iff (!reset_n)
        valid_ff && op_ff == FMA_OP_FMUL |-> res_ff.next_data[0] == res_ff.sel_data[W-1])
        else $error("multiply low sign bit differs");
    a_fault_no_store: assert property (@(posedge clock) disable iff (!reset_n)
        fault_ff |-> !res_ff.sel_wr && !res_ff.next_wr)
        else $error("faulted divide stored a result");
    a_zero_divisor: assert property (@(posedge clock) disable iff (!reset_n)
        req_valid && is_div && mag36(req.oper) == '0 |=> fault_ff)
        else $error("zero divisor did not fault");
    a_sub_zero_fault: assert property (@(posedge clock) disable iff (!reset_n)
        req_valid && req.op == FMA_OP_SFDIV && zero_sub |=> fault_ff && !res_ff.next_wr)
        else $error("substituted zero did not fault");
    a_short_keep_sel: assert property (@(posedge clock) disable iff (!reset_n)
        valid_ff && op_ff == FMA_OP_SFDIV |-> !res_ff.sel_wr)
        else $error("short divide wrote selected accumulator");
    a_ctrl_target: assert property (@(posedge clock) disable iff (!reset_n)
        req_valid && req.a_field == A_CTRL |=> res_ff.next_is_ctrl
        && (res_ff.next_addr == CTRL_ADDR_LO || res_ff.next_addr == CTRL_ADDR_HI))
        else $error("field seventeen missed control register");
    a_part_flags_kept: assert property (@(posedge clock) disable iff (!reset_n)
        req_valid && (req.op == FMA_OP_HADD || req.op == FMA_OP_HSUB
        || req.op == FMA_OP_TADD) |=> $stable(ovf_ff) && $stable(carry_ff))
        else $error("part-word op changed designators");
    a_dadd_zero: assert property (@(posedge clock) disable iff (!reset_n)
        req_valid && req.op == FMA_OP_DADD && pair == '0 && {req.oper, req.oper_next} == '1
        |=> res_ff.sel_data == '0 && res_ff.next_data == '0)
        else $error("mixed zero sum not plus zero");
    a_result_latency: assert property (@(posedge clock) disable iff (!reset_n)
        req_valid |=> valid_ff ##1 !valid_ff || $past(req_valid))
        else $error("result valid not one cycle after request");
    a_undef_div_only: assert property (@(posedge clock) disable iff (!reset_n)
        low_undefined |-> valid_ff && (op_ff == FMA_OP_IDIV || op_ff == FMA_OP_FDIV))
        else $error("undefined low word outside divide");
    a_fault_div_only: assert property (@(posedge clock) disable iff (!reset_n)
        fault_ff |-> valid_ff && (op_ff == FMA_OP_IDIV || op_ff == FMA_OP_SFDIV
        || op_ff == FMA_OP_FDIV))
        else $error("divide fault outside divide");
    c_mul_done: cover property (@(posedge clock) valid_ff && op_ff == FMA_OP_FMUL);
    c_div_fault: cover property (@(posedge clock) fault_ff);
    c_dadd_carry: cover property (@(posedge clock) valid_ff && op_ff == FMA_OP_DADD && carry_ff);
    c_thirds: cover property (@(posedge clock) valid_ff && op_ff == FMA_OP_TADD);
    c_undefined: cover property (@(posedge clock) low_undefined);
endmodule : fma_alu
`default_nettype wire

// ### dv/fma_store_model.sv
// Accumulator and control store that takes the result bundle back.
// Assumes each result follows its request by one cycle.
`timescale 1ns/10ps
`default_nettype none
module fma_store_model
    import fma_pkg::*;
(
    input wire logic     clock,
    input wire logic     req_valid,
    input wire fma_req_t req,
    input wire logic     res_valid,
    input wire fma_res_t res
);
    logic [W-1:0] mem [0:255];
    logic [3:0]   sel_ff;
    // =========================================================
    // Write-back, control words by address
    always @(posedge clock) begin
        if (req_valid)
            sel_ff <= req.a_field;
        if (res_valid && res.sel_wr)
            mem[{4'h0, sel_ff}] <= res.sel_data;
        if (res_valid && res.next_wr)
            mem[res.next_addr] <= res.next_data;
    end
endmodule : fma_store_model
`default_nettype wire

// ### dv/fixed_point_muldiv_partword_alu_tb_top.sv
// Self-checking bench for the fixed-point arithmetic section.
// Assumes fma_pkg, fma_alu and the store model compile first.
`timescale 1ns/10ps
`default_nettype none
module fixed_point_muldiv_partword_alu_tb_top
    import fma_pkg::*;
    ;
    logic        clock;
    logic        reset_n;
    logic        req_valid;
    fma_req_t    req;
    logic        res_valid;
    fma_res_t    res;
    logic        divide_fault;
    logic        overflow_flag;
    logic        carry_flag;
    logic        low_undefined;
    logic [3:0]  reg_addr;
    logic [31:0] reg_wdata;
    logic        reg_write;
    logic        reg_read;
    logic [31:0] reg_rdata;
    logic [31:0] lf;
    logic [35:0] a, u, am, um, q, rr;
    logic [70:0] dm;
    logic [71:0] x, y, yy;
    logic [72:0] t;
    logic        sg, ov, dsub;
    int          n_mismatch;
    int          num_checks;

    fma_alu u_dut (
        .clock(clock), .reset_n(reset_n), .req_valid(req_valid), .req(req),
        .res_valid(res_valid), .res(res), .divide_fault(divide_fault),
        .overflow_flag(overflow_flag), .carry_flag(carry_flag),
        .low_undefined(low_undefined), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata)
    );
    fma_store_model u_store (
        .clock(clock), .req_valid(req_valid), .req(req),
        .res_valid(res_valid), .res(res)
    );

    always #2.5 clock = ~clock;
    // =========================================================
    // Expectation helpers
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    function automatic logic [35:0] r36();
        logic [31:0] h;
        h = lf;
        lf = lfsr(lfsr(lf));
        return {h[3:0], lf};
    endfunction : r36
    function automatic logic [35:0] mg(input logic [35:0] v);
        return v[35] ? ~v : v;
    endfunction : mg
    function automatic logic [72:0] oca(input logic [71:0] p, input logic [71:0] s, input int w);
        logic [71:0] m;
        logic [72:0] r;
        logic        c;
        m = (w == 72) ? '1 : (72'h1 << w) - 72'h1;
        r = {1'b0, p} + {1'b0, s};
        c = r[w];
        r[71:0] = ((r[71:0] & m) + 72'(c)) & m;
        if (r[71:0] == m && !(p == m && s == m))
            r[71:0] = '0;
        return {c, r[71:0]};
    endfunction : oca
    function automatic logic [35:0] part(input logic [35:0] p, input logic [35:0] s,
                                         input int w);
        logic [35:0] m;
        logic [35:0] r;
        logic [72:0] o;
        m = (36'h1 << w) - 36'h1;
        r = '0;
        for (int k = 0; k < 36; k += w) begin
            o = oca(72'((p >> k) & m), 72'((s >> k) & m), w);
            r = r | (o[35:0] << k);
        end
        return r;
    endfunction : part
    function automatic logic [71:0] fmul(input logic [35:0] p, input logic [35:0] s);
        logic [71:0] r;
        r = 72'(mg(p)) * 72'(mg(s));
        if (p[35] ^ s[35])
            r = ~r;
        return {r[70:0], r[71]};
    endfunction : fmul
    // =========================================================
    // Drivers and checks
    task automatic finish_test();
        if (n_mismatch == 0 && num_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask : finish_test
    task automatic chk(input logic [71:0] got, input logic [71:0] exp);
        num_checks++;
        if (got !== exp) begin
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
            n_mismatch++;
        end
    endtask : chk
    task automatic run(input fma_op_t op, input logic [35:0] a0, a1, u0, u1,
                       input logic [3:0] af, xf, jf, input logic h);
        int k;
        @(posedge clock);
        req_valid <= 1'b1;
        req <= '{op, af, jf, xf, h, h, (h ? U_ALL_ONES : 16'h0), a0, a1, u0, u1};
        @(posedge clock);
        req_valid <= 1'b0;
        #1;
        k = 0;
        while (res_valid !== 1'b1 && k < 4) begin
            @(posedge clock);
            #1;
            k++;
        end
        if (k == 4) begin
            n_mismatch++;
            finish_test();
        end
    endtask : run
    task automatic wr(input logic [3:0] ad, input logic [31:0] d);
        @(posedge clock);
        reg_addr <= ad;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clock);
        reg_write <= 1'b0;
    endtask : wr
    task automatic rd(input logic [3:0] ad, input logic [31:0] exp);
        @(posedge clock);
        reg_addr <= ad;
        reg_read <= 1'b1;
        @(posedge clock);
        reg_read <= 1'b0;
        #1;
        chk(72'(reg_rdata), 72'(exp));
    endtask : rd
    task automatic pick();
        a = r36();
        u = r36();
        um = {2'b01, u[33:0]};
        am = {2'b00, a[33:0]};
        u = u[35] ? ~um : um;
        a = a[35] ? ~am : am;
        sg = a[35] ^ u[35];
    endtask : pick
    // =========================================================
    // Main sequence
    initial begin
        clock = 1'b0;
        lf = 32'h53;
        reset_n = 1'b0;
        req_valid = 1'b0;
        req = '0;
        reg_addr = 4'h0;
        reg_wdata = 32'h0;
        reg_write = 1'b0;
        reg_read = 1'b0;
        n_mismatch = 0;
        num_checks = 0;
        repeat (2) @(posedge clock);
        reset_n <= 1'b1;
        rd(REG_STATUS, 32'h0);
        rd(4'h8, 32'h0);
        for (int n = 0; n < 8; n++) begin
            a = r36();
            u = r36();
            run(FMA_OP_FMUL, a, 36'h0, u, 36'h0, 4'h3, X_NONE, 4'h0, 1'b0);
            chk({res.sel_data, res.next_data}, fmul(a, u));
            chk(72'(res.next_data[0]), 72'(res.sel_data[35]));
            chk(72'({res.next_is_ctrl, res.next_addr}), 72'h004);
        end
        for (int c = 0; c < 2; c++) begin
            wr(REG_CTRL, 32'(c));
            run(FMA_OP_FMUL, 36'h5, 36'h0, '1, '1, A_CTRL, X_NONE, c ? J_HI_B : J_HI_A, 1'b1);
            chk({res.sel_data, res.next_data}, 72'h0);
            rr = 36'({1'b1, c ? CTRL_ADDR_HI : CTRL_ADDR_LO});
            chk(72'({res.next_is_ctrl, res.next_addr}), 72'(rr));
            @(posedge clock);
            #1;
            chk(72'(u_store.mem[res.next_addr]), 72'h0);
        end
        run(FMA_OP_SFDIV, 36'h1, 36'h0, '1, 36'h0, 4'h2, X_NONE, J_HI_B, 1'b1);
        chk(72'({divide_fault, res.next_wr}), 72'h2);
        for (int n = 0; n < 6; n++) begin
            pick();
            q = 36'({am, 35'h0} / 71'(um));
            run(FMA_OP_SFDIV, a, 36'h0, u, 36'h0, 4'h4, X_NONE, 4'h0, 1'b0);
            chk(72'({res.next_wr, res.next_data}), 72'({1'b1, sg ? ~q : q}));
            run(FMA_OP_SFDIV, u, 36'h0, u, 36'h0, 4'h4, X_NONE, 4'h0, 1'b0);
            chk(72'({divide_fault, res.sel_wr, res.next_wr}), 72'h4);
            q = {2'b00, am[33:1], 1'b1};
            rr = {3'b000, am[32:0]} + 36'h1;
            dm = 71'(q) * 71'(um) + 71'(rr);
            x = a[35] ? ~{1'b0, dm} : {1'b0, dm};
            run(FMA_OP_IDIV, x[71:36], x[35:0], u, 36'h0, 4'h5, X_NONE, 4'h0, 1'b0);
            chk({res.sel_data, res.next_data}, {sg ? ~q : q, a[35] ? ~rr : rr});
            x = {1'b0, 71'(um) << 35};
            run(FMA_OP_IDIV, x[71:36], x[35:0], (n == 0) ? 36'h0 : u, 36'h0, 4'h5,
                X_NONE, 4'h0, 1'b0);
            chk(72'({divide_fault, res.sel_wr, res.next_wr}), 72'h4);
        end
        for (int k = 0; k < 6; k++) begin
            run(k < 3 ? FMA_OP_IDIV : FMA_OP_FDIV, 36'h5, 36'h0, 36'h5, 36'h0,
                4'(k % 3), 4'(4'hD + k % 3), 4'h0, 1'b1);
            chk(72'({low_undefined, divide_fault, res.sel_wr}), 72'h6);
        end
        run(FMA_OP_FDIV, 36'h1, 36'h0, 36'h2, 36'h0, 4'h7, X_NONE, 4'h0, 1'b0);
        chk(72'({low_undefined, divide_fault, res.sel_wr}), 72'h1);
        chk({res.sel_data, res.next_data}, {36'h4_0000_0000, 36'h0});
        for (int n = 0; n < 16; n++) begin
            x = {r36(), r36()};
            y = {r36(), r36()};
            dsub = (n > 7) ? n[2] : n[0];
            if (n > 7) begin
                x = {72{n[1]}};
                y = {72{n[0]}};
            end
            if (n == 15) begin
                x = {2'b10, 70'h0};
                y = ~x;
            end
            yy = dsub ? ~y : y;
            t = oca(x, yy, 72);
            ov = (x[71] == yy[71]) && (t[71] != x[71]);
            run(fma_op_t'(4'h5 + 4'(dsub)), x[71:36], x[35:0], y[71:36], y[35:0], 4'h8,
                X_NONE, 4'h0, 1'b0);
            chk({res.sel_data, res.next_data}, t[71:0]);
            chk(72'({carry_flag, overflow_flag}), 72'({t[72], ov}));
        end
        for (int n = 0; n < 12; n++) begin
            a = (n < 3) ? '1 : r36();
            u = (n < 3) ? '1 : r36();
            run(fma_op_t'(4'h7 + 4'(n % 3)), a, 36'h0, u, 36'h0, 4'h9, X_NONE, 4'h0, 1'b0);
            q = part(a, (n % 3 == 1) ? ~u : u, (n % 3 == 2) ? 12 : 18);
            chk(72'(res.sel_data), 72'(q));
            chk(72'({carry_flag, overflow_flag}), 72'h3);
        end
        rd(REG_STATUS, 32'h6);
        finish_test();
    end
endmodule : fixed_point_muldiv_partword_alu_tb_top
`default_nettype wire
